// File: core/swb_subtract_ops.sv
`timescale 1ns/1ns
`include "swb_defines.svh"

module swb_subtract_ops (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_exec,
    input wire logic [15:0] i_instr,
    input wire logic [7:0] i_f_rdata,
    input wire logic [3:0] i_bank_select_register,
    input wire logic i_ext_enable,
    input wire logic [4:0] i_status,
    output logic [7:0] o_w,
    output logic [11:0] o_f_addr,
    output logic [7:0] o_f_wdata,
    output logic o_f_we,
    output logic [4:0] o_status,
    output logic [2:0] o_mode,
    output logic o_done
);
    swb_pkg::swb_state_s state_ff;
    swb_pkg::swb_state_s nxt_state;

    logic is_fwb;
    logic is_wl;
    logic [7:0] op_a;
    logic [7:0] op_b;
    logic bin;
    logic [8:0] diff;
    logic [4:0] low;
    logic [7:0] res;
    logic accept;
    logic [7:0] instr_lo;
    logic carry_in;

    // Decode the two opcodes
    assign is_fwb = i_instr[15:10] == `SWB_OPC_FWB;
    assign is_wl = i_instr[15:8] == `SWB_OPC_WL;

    // Taken op, operand byte and incoming carry; other opcodes are ignored
    assign accept = i_exec && (is_fwb || is_wl);
    assign instr_lo = i_instr[7:0];
    assign carry_in = i_status[`SWB_FLG_C];

    // Operand selection; borrow is the inverted carry for file ops, zero for the literal op
    always_comb begin
        op_a = state_ff.w;
        op_b = i_f_rdata;
        bin = 1'h0;
        if (is_fwb) begin
            bin = ~i_status[`SWB_FLG_C];
        end else begin
            op_a = i_instr[7:0];
            op_b = state_ff.w;
        end
    end

    // Two's complement subtract, low nibble kept for digit carry
    assign diff = {1'h0, op_a} - {1'h0, op_b} - {8'h00, bin};
    assign low = {1'h0, op_a[3:0]} - {1'h0, op_b[3:0]} - {4'h0, bin};
    assign res = diff[7:0];

    // Next state
    always_comb begin
        nxt_state = state_ff;
        nxt_state.f_we = 1'h0;
        nxt_state.done = 1'h0;
        if (accept) begin
            nxt_state.status[`SWB_FLG_C] = ~diff[8];
            nxt_state.status[`SWB_FLG_DC] = ~low[4];
            nxt_state.status[`SWB_FLG_Z] = res == 8'h00;
            nxt_state.status[`SWB_FLG_N] = res[7];
            nxt_state.status[`SWB_FLG_OV] =
                (op_a[7] != op_b[7]) && (res[7] != op_a[7]);
            nxt_state.done = 1'h1;
            if (is_wl) begin
                nxt_state.w = res;
            end else begin
                if (i_instr[`SWB_BIT_A] == `SWB_ACC_BSR) begin
                    nxt_state.mode = swb_pkg::SWB_MODE_BANKED;
                    nxt_state.f_addr = {i_bank_select_register,
                        i_instr[7:0]};
                end else if (i_ext_enable &&
                        i_instr[7:0] <= `SWB_IDX_MAX) begin
                    nxt_state.mode = swb_pkg::SWB_MODE_INDEXED;
                    nxt_state.f_addr = {4'h0, i_instr[7:0]};
                end else begin
                    nxt_state.mode = swb_pkg::SWB_MODE_ACCESS;
                    nxt_state.f_addr = {(i_instr[7] ? 4'hF : 4'h0),
                        i_instr[7:0]};
                end
                if (i_instr[`SWB_BIT_D] == `SWB_DEST_W) begin
                    nxt_state.w = res;
                end else begin
                    nxt_state.f_data = res;
                    nxt_state.f_we = 1'h1;
                end
            end
        end
    end

    // Single register stage, one instruction cycle per operation
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            state_ff <= '{w: `SWB_W_RST, f_data: 8'h00, f_addr: 12'h000,
                f_we: 1'h0, status: 5'h00,
                mode: swb_pkg::SWB_MODE_ACCESS, done: 1'h0};
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign o_w = state_ff.w;
    assign o_f_addr = state_ff.f_addr;
    assign o_f_wdata = state_ff.f_data;
    assign o_f_we = state_ff.f_we;
    assign o_status = state_ff.status;
    assign o_mode = state_ff.mode;
    assign o_done = state_ff.done;

    // Checks sample operands at the taking edge and the answer one later
    sequence s_lit_op;
        i_exec && is_wl;
    endsequence

    sequence s_file_op;
        i_exec && is_fwb;
    endsequence

    // Done drops after one cycle unless the next op was taken at once
    sequence s_done_pulse;
        o_done ##1 (!o_done || $past(accept));
    endsequence

    chk_literal_result: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        s_lit_op |=> o_w == 8'($past(instr_lo) - $past(o_w)))
        else $error("literal subtract wrong");

    chk_literal_no_file: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        s_lit_op |=> !o_f_we && $stable(o_f_addr))
        else $error("literal subtract touched file");

    chk_dest_file: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (i_exec && is_fwb && i_instr[`SWB_BIT_D]) |=>
        o_f_we && $stable(o_w))
        else $error("file destination missed");

    chk_dest_w: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (i_exec && is_fwb && !i_instr[`SWB_BIT_D]) |=> !o_f_we &&
        o_w == 8'($past(o_w) - $past(i_f_rdata) -
            8'(!$past(carry_in))))
        else $error("W destination wrong");

    chk_borrow_math: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (i_exec && is_fwb && i_instr[`SWB_BIT_D]) |=>
        o_f_wdata == 8'($past(o_w) - $past(i_f_rdata) -
            8'(!$past(carry_in))))
        else $error("borrow subtract wrong");

    chk_bank_addr: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (i_exec && is_fwb && i_instr[`SWB_BIT_A]) |=>
        o_mode == swb_pkg::SWB_MODE_BANKED &&
        o_f_addr == {$past(i_bank_select_register), $past(instr_lo)})
        else $error("bank select ignored");

    chk_index_mode: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (i_exec && is_fwb && !i_instr[`SWB_BIT_A] && i_ext_enable &&
        instr_lo <= `SWB_IDX_MAX) |=>
        o_mode == swb_pkg::SWB_MODE_INDEXED &&
        o_f_addr == {4'h0, $past(instr_lo)})
        else $error("indexed mode missed");

    chk_access_addr: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (i_exec && is_fwb && !i_instr[`SWB_BIT_A] &&
        !(i_ext_enable && instr_lo <= `SWB_IDX_MAX)) |=>
        o_mode == swb_pkg::SWB_MODE_ACCESS &&
        o_f_addr[7:0] == $past(instr_lo) &&
        o_f_addr[11:8] == (o_f_addr[7] ? 4'hF : 4'h0))
        else $error("access bank address wrong");

    chk_zero_flag: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        s_lit_op |=> o_status[`SWB_FLG_Z] == (o_w == 8'h00))
        else $error("zero flag wrong");

    chk_file_zero: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        s_file_op |=> o_status[`SWB_FLG_Z] ==
        ((o_f_we ? o_f_wdata : o_w) == 8'h00))
        else $error("file zero flag wrong");

    chk_negative_flag: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        accept |=> o_status[`SWB_FLG_N] ==
        (o_f_we ? o_f_wdata[7] : o_w[7]))
        else $error("negative flag wrong");

    chk_literal_carry: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        s_lit_op |=> o_status[`SWB_FLG_C] ==
        ($past(instr_lo) >= $past(o_w)))
        else $error("carry flag wrong");

    chk_one_cycle: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        accept |=> s_done_pulse)
        else $error("done pulse wrong");

    chk_refused_idle: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        !accept |=> !o_done && !o_f_we && $stable(o_w) &&
        $stable(o_status))
        else $error("refused op changed state");
endmodule : swb_subtract_ops

// File: core/swb_defines.svh
`ifndef SWB_DEFINES_SVH
`define SWB_DEFINES_SVH

// Destination select values
`define SWB_DEST_W 1'h0
`define SWB_DEST_F 1'h1
// Access select values
`define SWB_ACC_BANK 1'h0
`define SWB_ACC_BSR 1'h1
// Highest file address handled in indexed literal offset mode
`define SWB_IDX_MAX 8'h5F
// Opcode fields: 0101 01da and 0000 1000
`define SWB_OPC_FWB 6'h15
`define SWB_OPC_WL 8'h08
// Instruction bits for destination select and access select
`define SWB_BIT_D 9
`define SWB_BIT_A 8
// Reset values
`define SWB_W_RST 8'h00
// Status flag bit positions
`define SWB_FLG_C 0
`define SWB_FLG_DC 1
`define SWB_FLG_Z 2
`define SWB_FLG_OV 3
`define SWB_FLG_N 4

`endif

// File: core/swb_pkg.sv
package swb_pkg;
    // Operand addressing modes
    typedef enum logic [2:0] {
        SWB_MODE_ACCESS = 3'h1,
        SWB_MODE_BANKED = 3'h2,
        SWB_MODE_INDEXED = 3'h4
    } swb_mode_e;

    // Registered state of the datapath
    typedef struct packed {
        logic [7:0] w;
        logic [7:0] f_data;
        logic [11:0] f_addr;
        logic f_we;
        logic [4:0] status;
        swb_mode_e mode;
        logic done;
    } swb_state_s;
endpackage : swb_pkg

// File: verification/swb_file_model.sv
`timescale 1ns/1ns
// File register model: unwritten words read back their address low byte
module swb_file_model (
    input wire logic i_clk_sys,
    input wire logic i_we,
    input wire logic [11:0] i_waddr,
    input wire logic [7:0] i_wdata,
    input wire logic [11:0] i_raddr,
    output logic [7:0] o_rdata
);
    logic [7:0] mem [0:4095];
    logic [4095:0] hit = '0;
    // Write-back lands on the edge after the pulse, like the real file
    always @(posedge i_clk_sys) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
            hit[i_waddr] <= 1'h1;
        end
    end
    assign o_rdata = hit[i_raddr] ? mem[i_raddr] : i_raddr[7:0];
endmodule : swb_file_model

// File: verification/tb_subtract_with_borrow_ops.sv
`timescale 1ns/1ns
module tb_subtract_with_borrow_ops;
    logic i_clk_sys = 1'h0;
    logic i_reset_n = 1'h0;
    logic i_exec = 1'h0;
    logic [15:0] i_instr = 16'h0000;
    logic [3:0] bank_sel = 4'h0;
    logic ext_en = 1'h0;
    logic [4:0] st = 5'h00;
    logic [11:0] ra = 12'h000;
    logic [7:0] rd, w, o_w, o_f_wdata;
    logic [11:0] o_f_addr;
    logic o_f_we, o_done;
    logic [4:0] o_status;
    logic [2:0] o_mode;
    int mismatches = 0;
    int compares = 0;
    // 250 MHz core clock
    always #2 i_clk_sys = ~i_clk_sys;
    swb_subtract_ops i_dut (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
        .i_exec(i_exec), .i_instr(i_instr), .i_f_rdata(rd),
        .i_bank_select_register(bank_sel), .i_ext_enable(ext_en),
        .i_status(st), .o_w(o_w), .o_f_addr(o_f_addr),
        .o_f_wdata(o_f_wdata), .o_f_we(o_f_we), .o_status(o_status),
        .o_mode(o_mode), .o_done(o_done));
    swb_file_model i_file (.i_clk_sys(i_clk_sys), .i_we(o_f_we),
        .i_waddr(o_f_addr), .i_wdata(o_f_wdata), .i_raddr(ra),
        .o_rdata(rd));
    // Reference: {N,OV,Z,DC,C} and a-b-bw, carry set when no borrow
    function automatic logic [12:0] ex(input logic [7:0] a,
        input logic [7:0] b, input logic bw);
        logic [8:0] r;
        logic [4:0] h;
        r = {1'h0, a} - {1'h0, b} - {8'h00, bw};
        h = {1'h0, a[3:0]} - {1'h0, b[3:0]} - {4'h0, bw};
        return {r[7], (a[7] != b[7]) && (r[7] != a[7]), r[7:0] == 8'h00,
            ~h[4], ~r[8], r[7:0]};
    endfunction : ex
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    // One strobe cycle; the answer must show exactly one cycle later
    task automatic op(input logic [15:0] ins, input logic [4:0] s);
        @(negedge i_clk_sys);
        i_instr = ins;
        i_exec = 1'h1;
        st = s;
        @(negedge i_clk_sys);
        i_exec = 1'h0;
        chk(o_done, 16'h0001);
    endtask : op
    task automatic lw(input logic [7:0] k);
        logic [12:0] e;
        e = ex(k, w, 1'h0);
        op({8'h08, k}, st);
        w = e[7:0];
        chk({o_status, o_w}, e);
    endtask : lw
    // File op: d, a, f, carry in, expected address, mode, file value
    task automatic fwb(input logic d, input logic a, input logic [7:0] f,
        input logic c, input logic [11:0] adr, input logic [2:0] md,
        input logic [7:0] v);
        logic [12:0] e;
        e = ex(w, v, ~c);
        ra = adr;
        op({6'h15, d, a, f}, {4'h0, c});
        if (d == 1'h0) w = e[7:0];
        chk({o_status, o_w}, {e[12:8], w});
        chk(o_f_we, d);
        if (d) chk(o_f_wdata, e[7:0]);
        chk(o_mode, md);
        // Indexed mode hands on the raw address; the offset comes later
        chk(o_f_addr, adr);
        @(negedge i_clk_sys);
        chk({o_f_we, o_done}, 16'h0000);
    endtask : fwb
    task automatic complete_run;
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : complete_run
    // Main sequence; second file op reads back the written result
    initial begin
        w = 8'h00;
        repeat (20) @(negedge i_clk_sys);
        i_reset_n = 1'h1;
        chk({o_mode, o_w}, 16'h0100);
        lw(8'h02);
        fwb(1'h1, 1'h0, 8'h03, 1'h1, 12'h003, 3'h1, 8'h03);
        fwb(1'h0, 1'h0, 8'h03, 1'h1, 12'h003, 3'h1, 8'hFF);
        lw(8'h08);
        bank_sel = 4'h5;
        fwb(1'h0, 1'h1, 8'h02, 1'h1, 12'h502, 3'h2, 8'h02);
        lw(8'h05);
        ext_en = 1'h1;
        fwb(1'h0, 1'h0, 8'h01, 1'h0, 12'h001, 3'h4, 8'h01);
        fwb(1'h0, 1'h0, 8'h5F, 1'h0, 12'h05F, 3'h4, 8'h5F);
        fwb(1'h1, 1'h0, 8'h60, 1'h1, 12'h060, 3'h1, 8'h60);
        ext_en = 1'h0;
        fwb(1'h1, 1'h0, 8'h90, 1'h0, 12'hF90, 3'h1, 8'h90);
        @(negedge i_clk_sys);
        i_instr = 16'h5C00;
        i_exec = 1'h1;
        @(negedge i_clk_sys);
        i_instr = 16'h0802;
        i_exec = 1'h0;
        @(negedge i_clk_sys);
        chk({o_done, o_w}, {8'h00, w});
        complete_run();
    end
endmodule : tb_subtract_with_borrow_ops
